// ### rtl/edb_top.sv
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "edb_regs.svh"
module edb_top
  import edb_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // AXI4-Lite write
  input  wire logic [15:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [15:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Host-out packet end from the serial engine
  input  wire logic        pkt_valid,
  input  wire edb_pkt_t    pkt,
  // Handshake answer and completion
  output var  edb_ans_t    ans,
  output var  logic        ans_valid,
  output var  logic        xfer_irq
);
  // Shared RAM, byte per entry; 512 bytes, FD80..FF7F
  logic [7:0]  ram_reg [`EDB_RAM_BYTES];
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [15:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        out0_ok_reg;

  // Write address/data may arrive in either order
  wire         aw_take  = s_axi_awvalid && s_axi_awready;
  wire         w_take   = s_axi_wvalid && s_axi_wready;
  wire         aw_have  = aw_held_reg || aw_take;
  wire         w_have   = w_held_reg || w_take;
  wire [15:0]  wa       = aw_held_reg ? awaddr_reg : s_axi_awaddr;
  wire [31:0]  wd       = w_held_reg ? wdata_reg : s_axi_wdata;
  wire [3:0]   ws       = w_held_reg ? wstrb_reg : s_axi_wstrb;
  wire         wr_fire  = aw_have && w_have && !s_axi_bvalid;
  wire [15:0]  wword    = {wa[15:2], 2'h0};
  wire         wr_inram = (wword >= `EDB_RAM_BASE) && (wword <= `EDB_RAM_LAST);
  wire         wr_stat  = (wword == `EDB_AXI_STAT);
  wire [8:0]   wr_idx   = 9'(wword - `EDB_RAM_BASE);

  wire         rd_fire  = s_axi_arvalid && s_axi_arready;
  wire [15:0]  rword    = {s_axi_araddr[15:2], 2'h0};
  wire         rd_inram = (rword >= `EDB_RAM_BASE) && (rword <= `EDB_RAM_LAST);
  wire         rd_stat  = (rword == `EDB_AXI_STAT);
  wire [8:0]   rd_idx   = 9'(rword - `EDB_RAM_BASE);

  // Descriptor of the output endpoint addressed by the packet
  wire [15:0]  desc_addr = 16'(`EDB_OUT1_BASE + ({14'h0, pkt.ep} - 16'h1 << `EDB_BLK_SHIFT));
  wire [8:0]   desc_idx  = 9'(desc_addr - `EDB_RAM_BASE);
  wire [7:0]   cfg       = ram_reg[desc_idx + 9'(`EDB_OFF_CONFIG)];
  wire         ep_ok     = (pkt.ep != 2'h0);
  // Y only when double buffering and sequence bit set
  wire         use_y     = cfg[`EDB_CFG_TWO_BUFFER_ENABLE] && cfg[`EDB_CFG_SEQ];
  wire [8:0]   base_idx  = desc_idx + 9'(use_y ? `EDB_OFF_YBASE : `EDB_OFF_XBASE);
  wire [8:0]   cnt_idx   = desc_idx + 9'(use_y ? `EDB_OFF_YCOUNT : `EDB_OFF_XCOUNT);
  wire [7:0]   cnt       = ram_reg[cnt_idx];
  wire         enabled   = cfg[`EDB_CFG_ENABLE] && ep_ok;
  wire         stalled   = cfg[`EDB_CFG_STALL];
  wire         full      = cnt[`EDB_CNT_NAK];
  // Start address: base byte with three zero low bits
  wire [10:0]  start     = {ram_reg[base_idx], 3'h0};
  // Mismatched sequence is a resend: ack it but store nothing
  wire         seq_ok    = (pkt.data_pid == cfg[`EDB_CFG_SEQ]);
  wire         accept    = pkt_valid && enabled && !stalled && !full;
  wire         store     = accept && seq_ok;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      awaddr_reg    <= 16'h0;
      wdata_reg     <= 32'h0;
      wstrb_reg     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `EDB_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_have && !s_axi_bvalid;
      s_axi_wready  <= !w_have && !s_axi_bvalid;
      if (aw_take) begin
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      aw_held_reg <= aw_have && !wr_fire;
      w_held_reg  <= w_have && !wr_fire;
      if (wr_fire) begin
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= (wr_inram || wr_stat) ? `EDB_RESP_OKAY : `EDB_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `EDB_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !rd_fire;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= (rd_inram || rd_stat) ? `EDB_RESP_OKAY : `EDB_RESP_SLVERR;
        if (rd_inram) begin
          s_axi_rdata <= {ram_reg[rd_idx + 9'h3], ram_reg[rd_idx + 9'h2],
                          ram_reg[rd_idx + 9'h1], ram_reg[rd_idx]};
        end else if (rd_stat) begin
          s_axi_rdata <= {16'h0, out0_ok_reg, 15'h0};
        end else begin
          s_axi_rdata <= 32'h0;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Byte lanes of the RAM; hardware updates win over a same-cycle bus write
  genvar gi;
  for (gi = 0; gi < `EDB_RAM_BYTES; gi++) begin : g_ram
    localparam logic [8:0] IDX = 9'(gi);
    localparam logic [1:0] LANE = 2'(gi);
    wire bus_hit = wr_fire && wr_inram && (wr_idx == {IDX[8:2], 2'h0}) && ws[LANE];
    wire cfg_hit = store && (IDX == desc_idx + 9'(`EDB_OFF_CONFIG));
    wire cnt_hit = store && (IDX == cnt_idx);
    // Descriptor blocks only; buffer bytes keep every bit
    localparam logic OUT_DESC = (IDX >= 9'(`EDB_OUT1_BASE - `EDB_RAM_BASE)) &&
                                (IDX < 9'(`EDB_OUT1_BASE + `EDB_DESC_SPAN - `EDB_RAM_BASE));
    localparam logic IN_DESC  = (IDX >= 9'(`EDB_IN1_BASE - `EDB_RAM_BASE)) &&
                                (IDX < 9'(`EDB_IN1_BASE + `EDB_DESC_SPAN - `EDB_RAM_BASE));
    localparam logic IS_DESC  = OUT_DESC || IN_DESC;
    logic [7:0] bus_byte;
    logic [7:0] hw_byte;
    always_comb begin
      bus_byte = wd[8*LANE +: 8];
      // Reserved bits read zero; base bytes are only ever bus-written
      if (IS_DESC && (IDX[2:0] == `EDB_OFF_CONFIG)) begin
        bus_byte = bus_byte & ~`EDB_CFG_RSV;
      end else if (IS_DESC && (IDX[2:0] == `EDB_OFF_SIZE)) begin
        bus_byte = bus_byte & ~`EDB_SIZE_RSV;
      end
      hw_byte = bus_hit ? bus_byte : ram_reg[gi];
      if (cfg_hit) begin
        hw_byte = ram_reg[gi] ^ (8'h1 << `EDB_CFG_SEQ);
      end
      if (cnt_hit) begin
        hw_byte = {1'b1, pkt.count};
      end
    end
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        ram_reg[gi] <= 8'h0;
      end else begin
        ram_reg[gi] <= hw_byte;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ans         <= '0;
      ans_valid   <= 1'b0;
      xfer_irq    <= 1'b0;
      out0_ok_reg <= 1'b0;
    end else begin
      ans_valid        <= pkt_valid;
      ans.ack          <= accept;
      ans.nak          <= pkt_valid && enabled && !stalled && full;
      ans.stall        <= pkt_valid && enabled && stalled;
      ans.ignore       <= pkt_valid && !enabled;
      ans.start_addr   <= start;
      // One-cycle completion pulse when enabled
      xfer_irq         <= store && cfg[`EDB_CFG_IRQEN];
      // Firmware-visible flag: last packet stored
      if (pkt_valid) begin
        out0_ok_reg <= store;
      end
    end
  end
endmodule
`default_nettype wire

// ### rtl/edb_regs.svh
`ifndef EDB_REGS_SVH
`define EDB_REGS_SVH
`define EDB_RAM_BASE    16'hfd80
`define EDB_RAM_LAST    16'hff7f
`define EDB_RAM_BYTES   512
`define EDB_BUF_LAST    16'hfeef
`define EDB_OUT0_BUF    16'hfef0
`define EDB_OUT0_LAST   16'hfef7
`define EDB_IN0_BUF     16'hfef8
`define EDB_IN0_LAST    16'hfeff
`define EDB_OUT1_BASE   16'hff08
`define EDB_IN1_BASE    16'hff48
`define EDB_DESC_SPAN   16'h0018
`define EDB_BLK_SHIFT   3
`define EDB_OFF_CONFIG  3'h0
`define EDB_OFF_XBASE   3'h1
`define EDB_OFF_XCOUNT  3'h2
`define EDB_OFF_YBASE   3'h5
`define EDB_OFF_YCOUNT  3'h6
`define EDB_OFF_SIZE    3'h7
`define EDB_CFG_IRQEN   2
`define EDB_CFG_STALL   3
`define EDB_CFG_TWO_BUFFER_ENABLE    4
`define EDB_CFG_SEQ     5
`define EDB_CFG_ISO     6
`define EDB_CFG_ENABLE  7
`define EDB_CNT_NAK     7
`define EDB_CFG_RSV     8'h03
`define EDB_SIZE_RSV    8'h80
`define EDB_AXI_STAT    16'h0000
`define EDB_STAT_BIT    15
`define EDB_RESP_OKAY   2'h0
`define EDB_RESP_SLVERR 2'h2
`endif

// ### rtl/edb_pkg.sv
`default_nettype none
package edb_pkg;
  typedef struct packed {
    logic [1:0] ep;
    logic [6:0] count;
    logic       data_pid;
  } edb_pkt_t;
  typedef struct packed {
    logic       ack;
    logic       nak;
    logic       stall;
    logic       ignore;
    logic [10:0] start_addr;
  } edb_ans_t;
  typedef enum logic [1:0] {EDB_IDLE, EDB_WDAT, EDB_RESP} edb_wstate_t;
endpackage
`default_nettype wire

// ### testbench/edb_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module edb_top_chk
  import edb_pkg::*;
(
  // Watched ports
  input wire logic     clk,
  input wire logic     rst_b,
  input wire logic     pkt_valid,
  input wire edb_pkt_t pkt,
  input wire edb_ans_t ans,
  input wire logic     ans_valid,
  input wire logic     xfer_irq,
  input wire logic     s_axi_bvalid,
  input wire logic     s_axi_bready
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  ans_late_a: assert property (pkt_valid |=> ans_valid)
    else $error("answer missing");
  ans_cause_a: assert property (ans_valid |-> $past(pkt_valid))
    else $error("answer without packet");
  irq_cause_a: assert property (xfer_irq |-> ans_valid && ans.ack)
    else $error("irq without stored packet");
  ep_zero_a: assert property (pkt_valid && pkt.ep == 2'h0 |=> ans.ignore && !xfer_irq)
    else $error("endpoint zero serviced");
  one_answer_a: assert property (ans_valid |-> $onehot({ans.ack, ans.nak, ans.stall, ans.ignore}))
    else $error("answer not one-hot");
  stall_quiet_a: assert property (ans_valid && ans.stall |-> !xfer_irq)
    else $error("irq on stall");
  addr_align_a: assert property (ans_valid && ans.ack |-> ans.start_addr[2:0] == 3'h0)
    else $error("start address unaligned");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
endmodule
bind edb_top edb_top_chk u_chk (.clk(clk), .rst_b(rst_b), .pkt_valid(pkt_valid), .pkt(pkt),
  .ans(ans), .ans_valid(ans_valid), .xfer_irq(xfer_irq), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready));
`default_nettype wire

// ### testbench/edb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module edb_host_model
  import edb_pkg::*;
(
  // Packet end toward the block
  input  wire logic     clk,
  output var  logic     pkt_valid,
  output var  edb_pkt_t pkt
);
  initial begin
    pkt_valid = 1'b0;
    pkt = '0;
  end
  task automatic send(input logic [1:0] ep, input logic [6:0] cnt, input logic pid);
    @(posedge clk);
    pkt_valid <= 1'b1;
    pkt <= '{ep: ep, count: cnt, data_pid: pid};
    @(posedge clk);
    pkt_valid <= 1'b0;
    // Payload not held: stale values must not look valid
    pkt <= ~pkt;
  endtask
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top import edb_pkg::*;;
  localparam logic [1:0] OK = 2'h0;
  localparam logic [1:0] SE = 2'h2;
  logic clk = 1'b0;
  logic rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic pkt_valid, ans_valid, xfer_irq;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  edb_pkt_t    pkt;
  edb_ans_t    ans;
  int          n_mismatch, check_count;
  always #2.5 clk = ~clk;
  edb_top u_dut (.clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .pkt_valid, .pkt, .ans, .ans_valid, .xfer_irq);
  edb_host_model u_host (.clk(clk), .pkt_valid(pkt_valid), .pkt(pkt));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic hang(input logic ok);
    chk("handshake", 32'h1, {31'h0, ok});
    if (!ok) tally_and_finish();
  endtask
  task automatic axi_wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    logic ah, wh, done;
    done = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 40 && !done; n++) begin
      // Sample mid-cycle: what the next rising edge will see
      @(negedge clk);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      done = s_axi_bvalid;
      if (done) chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
      @(posedge clk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
      if (done) s_axi_bready <= 1'b0;
    end
    hang(done);
  endtask
  task automatic axi_rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge clk);
      done = s_axi_rvalid;
      if (done) chk("rdata", ed, s_axi_rdata);
      if (done) chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (done) s_axi_rready <= 1'b0;
    end
    hang(done);
  endtask
  // Flags ea = {ack, nak, stall, ignore}; address only meaningful on ack
  task automatic pkt_chk(input logic [1:0] ep, input logic [6:0] c, input logic pid,
                         input logic [3:0] ea, input logic [10:0] adr, input logic irq);
    u_host.send(ep, c, pid);
    @(negedge clk);
    chk("ans_valid", 32'h1, {31'h0, ans_valid});
    chk("ans_flags", {28'h0, ea}, {28'h0, ans.ack, ans.nak, ans.stall, ans.ignore});
    if (ea[3]) chk("start_addr", {21'h0, adr}, {21'h0, ans.start_addr});
    chk("xfer_irq", {31'h0, irq}, {31'h0, xfer_irq});
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    rst_b = 1'b0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    axi_rd(16'hff08, 32'h0, OK);
    axi_rd(16'h1000, 32'h0, SE);
    axi_wr(16'hff80, 32'h1, 4'hf, SE);
    axi_wr(16'hff0c, 32'hffaabbcc, 4'hf, OK);
    axi_rd(16'hff0c, 32'h7faabbcc, OK);
    axi_wr(16'hfd80, 32'hffffffff, 4'hf, OK);
    axi_rd(16'hfd80, 32'hffffffff, OK);
    axi_wr(16'hfef4, 32'hffffffff, 4'hf, OK);
    axi_rd(16'hfef4, 32'hffffffff, OK);
    axi_wr(16'hfef8, 32'hffffffff, 4'hf, OK);
    axi_rd(16'hfef8, 32'hffffffff, OK);
    axi_wr(16'hff48, 32'h000000bf, 4'h1, OK);
    axi_rd(16'hff48, 32'h000000bc, OK);
    $display("test map done");
    axi_wr(16'hff08, 32'h00001287, 4'hf, OK);
    pkt_chk(2'h1, 7'h05, 1'b0, 4'h8, 11'h090, 1'b1);
    axi_rd(16'hff08, 32'h008512a4, OK);
    pkt_chk(2'h1, 7'h03, 1'b1, 4'h4, 11'h0, 1'b0);
    $display("test x buffer done");
    axi_wr(16'hff0c, 32'h00002000, 4'h6, OK);
    axi_wr(16'hff08, 32'h000012b0, 4'hf, OK);
    pkt_chk(2'h1, 7'h07, 1'b1, 4'h8, 11'h100, 1'b0);
    axi_rd(16'hff0c, 32'h7f8720cc, OK);
    $display("test y buffer done");
    axi_wr(16'hff08, 32'h00000088, 4'hf, OK);
    pkt_chk(2'h1, 7'h01, 1'b0, 4'h2, 11'h0, 1'b0);
    axi_wr(16'hff08, 32'h00000004, 4'hf, OK);
    pkt_chk(2'h1, 7'h01, 1'b0, 4'h1, 11'h0, 1'b0);
    pkt_chk(2'h0, 7'h01, 1'b0, 4'h1, 11'h0, 1'b0);
    for (int e = 2; e < 4; e++) begin
      axi_wr(16'hff00 + 16'(8 * e), 32'h00003080, 4'hf, OK);
      pkt_chk(e[1:0], 7'h02, 1'b0, 4'h8, 11'h180, 1'b0);
    end
    axi_rd(16'h0000, 32'h00008000, OK);
    axi_wr(16'hff18, 32'h00003084, 4'hf, OK);
    pkt_chk(2'h3, 7'h02, 1'b1, 4'h8, 11'h180, 1'b0);
    axi_rd(16'hff18, 32'h00003084, OK);
    axi_rd(16'h0000, 32'h00000000, OK);
    $display("test refusals done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
